//--- src/brqt_pkg.sv
// Purpose: Shared constants and types for the burst read query table.
// Assumes: Byte address = 4 x table index; table bytes sit in bits 7:0.
// Notes:   Table contents are fixed; only the control word is writable.
package brqt_pkg;

    // Bus geometry
    localparam int unsigned BRQT_AW = 12;
    localparam int unsigned BRQT_IW = 10;
    localparam int unsigned BRQT_DW = 32;
    localparam int unsigned BRQT_QW = 16;

    // Table indices, byte address is four times these
    localparam logic [BRQT_IW-1:0] IDX_PAGE_READ_CAP   = 10'h127;
    localparam logic [BRQT_IW-1:0] IDX_SYNC_FIELD_CNT  = 10'h128;
    localparam logic [BRQT_IW-1:0] IDX_BURST_CAP_FIRST = 10'h129;
    localparam logic [BRQT_IW-1:0] IDX_BURST_CAP_SECOND = 10'h12A;
    localparam logic [BRQT_IW-1:0] IDX_BURST_CAP_THIRD = 10'h12B;
    localparam logic [BRQT_IW-1:0] IDX_PART_REGION_CNT = 10'h12C;
    // Block-local control and status words
    localparam logic [BRQT_IW-1:0] IDX_CTRL            = 10'h100;
    localparam logic [BRQT_IW-1:0] IDX_STATUS          = 10'h101;

    // Fixed table contents
    localparam logic [7:0] PAGE_CAP_NONMUX  = 8'h05;
    localparam logic [7:0] PAGE_CAP_MUX     = 8'h00;
    localparam logic [7:0] SYNC_FIELD_CNT   = 8'h03;
    localparam logic [7:0] BURST_CFG_FIRST  = 8'h02;
    localparam logic [7:0] BURST_CFG_SECOND = 8'h03;
    localparam logic [7:0] BURST_CFG_THIRD  = 8'h07;
    localparam logic [2:0] BURST_CONT_CODE  = 3'h7;
    localparam logic [7:0] PART_REGION_DFLT = 8'h00;

    // Control word layout and reset
    localparam int unsigned CTRL_QEN_BIT = 0;
    localparam int unsigned CTRL_MUX_BIT = 1;
    localparam logic [1:0]  CTRL_RST     = 2'h0;
    localparam logic [15:0] QCOUNT_RST   = 16'h0000;

    // Register port request
    typedef struct packed {
        logic [BRQT_AW-1:0] addr;
        logic [BRQT_DW-1:0] wdata;
        logic               wr;
        logic               rd;
    } brqt_bus_req_t;

    // Query-mode read request
    typedef struct packed {
        logic [BRQT_IW-1:0] addr;
        logic               rd;
    } brqt_qreq_t;

    // Burst words for a 3-bit length code; zero means continuous
    function automatic logic [7:0] brqt_burst_words(input logic [2:0] code);
        logic [7:0] words;
        words = 8'h00;
        if (code != BURST_CONT_CODE) begin
            words = 8'(9'h001 << (code + 3'h1));
        end
        return words;
    endfunction

endpackage

//--- src/brqt_rom.sv
// Purpose: Constant lookup of the burst read query bytes.
// Assumes: Purely combinational; caller registers the result.
// Notes:   hit_o is low for any index outside the table.
`timescale 1ns/1ns
`default_nettype none
module brqt_rom #(
    parameter logic [7:0] PART_REGIONS = brqt_pkg::PART_REGION_DFLT
) (
    input  wire logic [brqt_pkg::BRQT_IW-1:0] idx_i,      // Table index
    input  wire logic                         mux_mode_i, // Address-data mux variant
    output logic      [7:0]                   byte_o,     // Table byte
    output logic                              hit_o       // Index is in table
);
    import brqt_pkg::*;

    // Table decode; upper config bits are reserved and read zero
    always_comb begin
        byte_o = 8'h00;
        hit_o  = 1'b1;
        case (idx_i)
            IDX_PAGE_READ_CAP: begin
                // Mux variant has no page buffer
                byte_o = mux_mode_i ? PAGE_CAP_MUX : PAGE_CAP_NONMUX;
            end
            IDX_SYNC_FIELD_CNT: begin
                byte_o = SYNC_FIELD_CNT;
            end
            IDX_BURST_CAP_FIRST: begin
                byte_o = BURST_CFG_FIRST;
            end
            IDX_BURST_CAP_SECOND: begin
                byte_o = BURST_CFG_SECOND;
            end
            IDX_BURST_CAP_THIRD: begin
                byte_o = BURST_CFG_THIRD;
            end
            IDX_PART_REGION_CNT: begin
                byte_o = PART_REGIONS;
            end
            default: begin
                hit_o = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

//--- src/brqt_top.sv
// Summary of operation
// - Page capability byte is n for 2^n page bytes: 05 normal, 00 muxed.
// - Next byte counts the burst configuration fields following; this device reports three.
// - Config byte low three bits n give 2^(n+1) word burst; first is 02.
// - Config code 07 means continuous linear burst to end of space.
// - Second burst configuration byte reads 03, a 16-word burst.
// - Third burst configuration byte reads 07, continuous bursting.
// - Partition-region count byte; zero means single partition, no more fields.
//
// Purpose: Register-port slave and query-mode read port for the table.
// Assumes: All inputs come from logic on clk_i; strobes are one cycle.
// Notes:   Read data stand one cycle after the strobe and read zero else.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module brqt_top #(
    parameter logic [7:0] PART_REGIONS = brqt_pkg::PART_REGION_DFLT
) (
    input  wire logic                           clk_i,      // 100 MHz clock
    input  wire logic                           resetn_i,   // Sync reset, low
    input  wire brqt_pkg::brqt_bus_req_t        bus_req_i,  // Register port
    output logic      [brqt_pkg::BRQT_DW-1:0]   rdata_o,    // Read data
    input  wire brqt_pkg::brqt_qreq_t           q_req_i,    // Query read
    output logic      [brqt_pkg::BRQT_QW-1:0]   q_data_o,   // Query data
    output logic                                q_valid_o,  // Query data valid
    output logic                                mux_mode_o  // Mux variant flag
);
    import brqt_pkg::*;

    // Control state
    logic [1:0]         ctrl_r;
    logic [1:0]         ctrl_nxt;
    // Register port read path
    logic [BRQT_DW-1:0] rdata_r;
    logic [BRQT_DW-1:0] rdata_nxt;
    // Query port path
    logic [BRQT_QW-1:0] qdata_r;
    logic [BRQT_QW-1:0] qdata_nxt;
    logic               qvalid_r;
    logic               qvalid_nxt;
    logic [15:0]        qcount_r;
    logic [15:0]        qcount_nxt;
    logic               qmiss_r;
    logic               qmiss_nxt;

    // Decoded request fields
    logic [BRQT_IW-1:0] bus_idx;
    logic               bus_aligned;
    logic [7:0]         bus_byte;
    logic               bus_hit;
    logic [7:0]         q_byte;
    logic               q_hit;
    logic               q_take;

    assign bus_idx     = bus_req_i.addr[BRQT_AW-1:2];
    assign bus_aligned = (bus_req_i.addr[1:0] == 2'h0);
    assign q_take      = q_req_i.rd && ctrl_r[CTRL_QEN_BIT];

    // Two lookups so both ports can read in the same cycle
    brqt_rom #(
        .PART_REGIONS (PART_REGIONS)
    ) u_bus_rom (
        .idx_i      (bus_idx),
        .mux_mode_i (ctrl_r[CTRL_MUX_BIT]),
        .byte_o     (bus_byte),
        .hit_o      (bus_hit)
    );

    brqt_rom #(
        .PART_REGIONS (PART_REGIONS)
    ) u_q_rom (
        .idx_i      (q_req_i.addr),
        .mux_mode_i (ctrl_r[CTRL_MUX_BIT]),
        .byte_o     (q_byte),
        .hit_o      (q_hit)
    );

    // Control word: only writable state; table writes are dropped
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (bus_req_i.wr && bus_aligned && (bus_idx == IDX_CTRL)) begin
            ctrl_nxt = bus_req_i.wdata[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_r <= CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Register read mux; unmapped or misaligned reads return zero
    always_comb begin
        rdata_nxt = '0;
        if (bus_req_i.rd && bus_aligned) begin
            if (bus_hit) begin
                rdata_nxt = {24'h000000, bus_byte};
            end else if (bus_idx == IDX_CTRL) begin
                rdata_nxt = {30'h00000000, ctrl_r};
            end else if (bus_idx == IDX_STATUS) begin
                rdata_nxt = {qcount_r, 15'h0000, qmiss_r};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Query read: byte on the low lane, upper lane held at zero
    always_comb begin
        qdata_nxt  = '0;
        qvalid_nxt = q_take;
        qcount_nxt = qcount_r;
        qmiss_nxt  = qmiss_r;
        if (q_take) begin
            qdata_nxt  = {8'h00, (q_hit ? q_byte : 8'h00)};
            qcount_nxt = qcount_r + 16'h0001;                  // Wraps silently
            qmiss_nxt  = !q_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            qdata_r  <= '0;
            qvalid_r <= 1'b0;
            qcount_r <= QCOUNT_RST;
            qmiss_r  <= 1'b0;
        end else begin
            qdata_r  <= qdata_nxt;
            qvalid_r <= qvalid_nxt;
            qcount_r <= qcount_nxt;
            qmiss_r  <= qmiss_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o    = rdata_r;
    assign q_data_o   = qdata_r;
    assign q_valid_o  = qvalid_r;
    assign mux_mode_o = ctrl_r[CTRL_MUX_BIT];

    // Helpers for the checks below
    logic [BRQT_IW-1:0] chk_idx;
    logic               chk_rd;
    assign chk_idx = bus_idx;
    assign chk_rd  = bus_req_i.rd && bus_aligned;

    // Page capability follows the variant chosen at read time
    page_cap_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_PAGE_READ_CAP)
        |=> (rdata_o == ($past(ctrl_r[CTRL_MUX_BIT]) ? 32'h00000000 : 32'h00000005))
    ) else $error("page capability byte wrong");

    // Field count reads three
    field_cnt_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_SYNC_FIELD_CNT) |=> (rdata_o == 32'h00000003)
    ) else $error("field count byte wrong");

    // First configuration is an eight-word burst, reserved bits clear
    cfg_first_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_BURST_CAP_FIRST)
        |=> (rdata_o[7:3] == 5'h00) && (brqt_burst_words(rdata_o[2:0]) == 8'h08)
    ) else $error("first burst config wrong");

    // Second configuration is a sixteen-word burst
    cfg_second_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_BURST_CAP_SECOND)
        |=> (rdata_o == 32'h00000003) && (brqt_burst_words(rdata_o[2:0]) == 8'h10)
    ) else $error("second burst config wrong");

    // Third configuration reads the continuous code
    cfg_third_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_BURST_CAP_THIRD) |=> (rdata_o == 32'h00000007)
    ) else $error("third burst config wrong");

    // Continuous code decodes to no fixed length
    cont_code_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_BURST_CAP_THIRD)
        |=> (rdata_o[2:0] == BURST_CONT_CODE) && (brqt_burst_words(rdata_o[2:0]) == 8'h00)
    ) else $error("continuous burst code wrong");

    // Partition count carries the configured region number
    part_count_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_PART_REGION_CNT) |=> (rdata_o == {24'h000000, PART_REGIONS})
    ) else $error("partition region count wrong");

    // Query answer lands one cycle later, upper lane zero
    query_lane_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (q_req_i.rd && ctrl_r[CTRL_QEN_BIT] && q_req_i.addr == IDX_SYNC_FIELD_CNT)
        |=> q_valid_o && (q_data_o == 16'h0003)
    ) else $error("query byte not on low lane");

    // Upper lane never carries data
    query_upper_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        q_valid_o |-> (q_data_o[15:8] == 8'h00)
    ) else $error("query upper lane not zero");

    // Query disabled means no answer
    query_off_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (!ctrl_r[CTRL_QEN_BIT] || !q_req_i.rd) |=> !q_valid_o && (q_data_o == 16'h0000)
    ) else $error("query answered while disabled");

    // Read data only stand in the cycle after a read strobe
    rdata_idle_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !bus_req_i.rd |=> (rdata_o == 32'h00000000)
    ) else $error("read data outside read slot");

    // Control write shows on the mux flag one edge later
    ctrl_write_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.wr && bus_aligned && bus_idx == IDX_CTRL)
        |=> (mux_mode_o == $past(bus_req_i.wdata[CTRL_MUX_BIT]))
    ) else $error("control write lost");

    // Without an aligned control write the control word holds
    ctrl_hold_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !(bus_req_i.wr && bus_aligned && bus_idx == IDX_CTRL) |=> $stable(ctrl_r)
    ) else $error("control word changed without write");

    // Control word reads back in the low bits
    ctrl_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_CTRL) |=> (rdata_o == {30'h0, $past(ctrl_r)})
    ) else $error("control readback wrong");

    // Status carries the query count with a clear middle field
    status_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_STATUS)
        |=> (rdata_o[31:16] == $past(qcount_r)) && (rdata_o[15:1] == 15'h0000)
    ) else $error("status readback wrong");

    // Misaligned reads return zero
    misalign_zero_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.rd && !bus_aligned) |=> (rdata_o == 32'h00000000)
    ) else $error("misaligned read not zero");

    // Unmapped aligned reads return zero
    unmapped_zero_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && !bus_hit && chk_idx != IDX_CTRL && chk_idx != IDX_STATUS)
        |=> (rdata_o == 32'h00000000)
    ) else $error("unmapped read not zero");

    // Every accepted query is answered on the next edge
    query_valid_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        q_take |=> q_valid_o
    ) else $error("accepted query not answered");

    // A query outside the table answers zero and flags the miss
    query_miss_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        (q_take && !q_hit) |=> (q_data_o == 16'h0000) && qmiss_r
    ) else $error("query miss not reported");

    // Each accepted query bumps the count by one
    query_count_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        q_take |=> (qcount_r == $past(qcount_r) + 16'h0001)
    ) else $error("query count not advanced");

    // Main scenarios
    miss_status_c: cover property (
        @(posedge clk_i) disable iff (!resetn_i)
        (q_take && !q_hit) ##[1:8] (chk_rd && chk_idx == IDX_STATUS)
    );

    rd_cont_c: cover property (
        @(posedge clk_i) disable iff (!resetn_i)
        (chk_rd && chk_idx == IDX_BURST_CAP_THIRD) ##1 (rdata_o == 32'h00000007)
    );

    mux_page_c: cover property (
        @(posedge clk_i) disable iff (!resetn_i)
        ctrl_r[CTRL_MUX_BIT] && chk_rd && chk_idx == IDX_PAGE_READ_CAP
    );

    query_seq_c: cover property (
        @(posedge clk_i) disable iff (!resetn_i)
        q_take ##1 q_take ##1 q_valid_o
    );

    wr_then_rd_c: cover property (
        @(posedge clk_i) disable iff (!resetn_i)
        (bus_req_i.wr && bus_idx == IDX_CTRL) ##1 (chk_rd && chk_idx == IDX_CTRL)
    );

endmodule
`default_nettype wire

//--- tb/brqt_host_model.sv
// Purpose: Host-side model that issues query reads and keeps a burst length code.
// Assumes: Device runs at its maximum word width, so the code copy is valid.
// Notes:   A released index shows the inverse of the last one, never a stale index.
`timescale 1ns/1ns
`default_nettype none
module brqt_host_model (
    input  wire logic                 clk_i,             // Clock
    output var  brqt_pkg::brqt_qreq_t q_req_o,           // Query request
    input  wire logic [15:0]          q_data_i,          // Query data
    input  wire logic                 q_valid_i,         // Query data valid
    output logic      [2:0]           read_config_reg_o  // Burst length field
);
    import brqt_pkg::*;
    logic [BRQT_IW-1:0] last_idx;
    // Quiet port at time zero
    initial begin
        q_req_o = '0;
        read_config_reg_o = 3'h0;
        last_idx = '0;
    end
    // Strobe and index change after an edge and stand until the next query or release
    task automatic query(input logic [BRQT_IW-1:0] idx);
        @(posedge clk_i);
        q_req_o <= '{addr: idx, rd: 1'b1};
    endtask
    // Inverted index on release so a late sample cannot pass for a request
    task automatic release_port();
        @(posedge clk_i);
        q_req_o <= '{addr: ~q_req_o.addr, rd: 1'b0};
    endtask
    // Each burst configuration byte's length code is copied unchanged
    always @(posedge clk_i) begin
        last_idx <= q_req_o.addr;
        if (q_valid_i && last_idx >= 10'h129 && last_idx <= 10'h12B) begin
            read_config_reg_o <= q_data_i[2:0];
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the burst read query table.
// Assumes: Expected bytes are the documented table values, not the design's.
// Notes:   Drivers queue expectations; monitors pop them when results appear.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import brqt_pkg::*;
    localparam logic [7:0] PREG = 8'h01;
    logic          clk_i;
    logic          resetn_i;
    brqt_bus_req_t bus_req;
    logic [31:0]   rdata;
    brqt_qreq_t    q_req;
    logic [15:0]   q_data;
    logic          q_valid;
    logic          mux_mode;
    logic [2:0]    cfg_len;
    logic          rd_d = 1'b0;
    int            mismatches = 0;
    int            checks_done = 0;
    int            nq = 0;
    logic [31:0]   exp_r[$];
    logic [15:0]   exp_q[$];
    logic [7:0]    tab[6] = '{8'h05, 8'h03, 8'h02, 8'h03, 8'h07, PREG};

    brqt_top #(.PART_REGIONS(PREG)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .bus_req_i(bus_req), .rdata_o(rdata), .q_req_i(q_req), .q_data_o(q_data),
        .q_valid_o(q_valid), .mux_mode_o(mux_mode));
    brqt_host_model host (.clk_i(clk_i), .q_req_o(q_req), .q_data_i(q_data),
        .q_valid_i(q_valid), .read_config_reg_o(cfg_len));

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Compare tasks, one per result width
    task automatic check32(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic check16(input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Register port requests; each waits an edge so requests may run back to back
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_i);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        exp_r.push_back(e);
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask
    task automatic idle(input int n);
        @(posedge clk_i);
        bus_req <= '0;
        repeat (n) @(posedge clk_i);
    endtask
    // Query through the host model; refused queries expect nothing
    task automatic qry(input logic [9:0] i, input logic [15:0] e, input logic take);
        host.query(i);
        if (take) begin
            exp_q.push_back(e);
            nq++;
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Read data must stand only in the cycle after the strobe, zero otherwise
    always @(posedge clk_i) begin
        rd_d <= bus_req.rd;
        if (rd_d) begin
            check32(exp_r.pop_front(), rdata);
        end else if (resetn_i) begin
            check32(32'h0, rdata);
        end
    end
    // Every query answer must have been asked for
    always @(posedge clk_i) begin
        if (q_valid === 1'b1) begin
            check32(32'h1, {31'h0, exp_q.size() > 0});
            if (exp_q.size() > 0) check16(exp_q.pop_front(), q_data);
        end
    end

    // Main sequence
    initial begin
        resetn_i = 1'b0;
        bus_req = '0;
        void'($urandom(32'hc539));
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(negedge clk_i);
        check32(32'(mux_mode), 32'h0);
        // Table twice; second pass writes random data first, which must not stick
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 6; i++) begin
                if (k == 1) reg_wr({10'h127 + 10'(i), 2'b00}, $urandom);
                reg_rd({10'h127 + 10'(i), 2'b00}, {24'h0, tab[i]});
            end
        end
        // Unmapped and misaligned places read zero
        reg_rd({2'b00, 8'($urandom), 2'b00}, 32'h0);
        reg_rd(12'h4AD, 32'h0);
        idle(0);
        // Disabled query port ignores the strobe
        qry(10'h128, 16'h0, 1'b0);
        host.release_port();
        reg_wr(12'h400, 32'h1);
        reg_rd(12'h400, 32'h1);
        idle(0);
        // Back-to-back queries over the whole table, upper byte zero
        for (int i = 0; i < 6; i++) qry(10'h127 + 10'(i), {8'h00, tab[i]}, 1'b1);
        host.release_port();
        repeat (2) @(negedge clk_i);
        check32(32'(cfg_len), 32'h7);
        // First configuration alone gives the 8-word code; a miss leaves it
        qry(10'h129, 16'h0002, 1'b1);
        qry(10'h0FF, 16'h0000, 1'b1);
        host.release_port();
        repeat (2) @(negedge clk_i);
        check32(32'(cfg_len), 32'h2);
        // The miss just taken must show in the status word
        reg_rd(12'h404, {16'(nq), 15'h0, 1'b1});
        // Multiplexed variant reports no page buffer
        reg_wr(12'h400, 32'h3);
        reg_rd(12'h49C, 32'h0);
        idle(0);
        qry(10'h127, 16'h0000, 1'b1);
        host.release_port();
        reg_rd(12'h404, {16'(nq), 15'h0, 1'b0});
        idle(3);
        @(negedge clk_i);
        check32(32'(mux_mode), 32'h1);
        check32(32'(exp_q.size() + exp_r.size()), 32'h0);
        print_verdict();
    end
    // Watchdog well beyond the expected fifty-odd cycles
    initial begin
        repeat (2000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
